/* File: hw/slfm_top.sv */
// Fault supervision and pulse catch-up logic for two slave clock lines.
`timescale 1ns/1ps

// Each line runs a small pulse sequencer in pulse mode and a gated
// time-code path otherwise; the common alarm collects every fault.
// Counts of tenths come from one shared divider so all lines step
// together and no second clock domain is needed.
module slfm_top #(
   parameter int unsigned NUM_LINES = 2,
   parameter int unsigned TENTH_CYCLES = slfm_pkg::TENTH_CYC,
   parameter bit BACKUP_FITTED = 1'b1
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [7:0] cfg_byte_i,
   input wire logic sys_ok_i,
   input wire logic radio_sync_status_i,
   input wire logic minute_tick_i,
   input wire logic second_tick_i,
   input wire logic [NUM_LINES-1:0] tc_bit_i,
   input wire logic [NUM_LINES-1:0] line_is_sec_i,
   input wire logic [NUM_LINES-1:0][4:0] pw_tenths_i,
   input wire logic [NUM_LINES-1:0][slfm_pkg::MON_W-1:0] mon_level_i,
   input wire logic [slfm_pkg::MON_W-1:0] mon_thresh_i,
   output logic alarm_relay_o,
   output logic host_err_o,
   output slfm_pkg::slfm_line_out_t [NUM_LINES-1:0] line_o,
   output logic [NUM_LINES-1:0][slfm_pkg::TIME_W-1:0] line_time_o
);
   import slfm_pkg::*;

   // -------------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------------
   // Only one or two lines exist, and the divider needs two states.
   if (NUM_LINES < 1 || NUM_LINES > 2) begin : g_chk_lines
      $error("NUM_LINES must be 1 or 2");
   end
   if (TENTH_CYCLES < 2) begin : g_chk_tenth
      $error("TENTH_CYCLES must be at least 2");
   end

   // The divider is just wide enough to count one tenth of a second.
   localparam int unsigned DIV_W = $clog2(TENTH_CYCLES);

   // -------------------------------------------------------------------
   // Configuration and tenth-second enable
   // -------------------------------------------------------------------
   slfm_cfg_t cfg;
   logic [DIV_W-1:0] div_r, div_nxt;
   logic tenth_r, tenth_nxt;
   // Per-line fault flags, one continuous assignment per line below.
   wire [NUM_LINES-1:0] line_fault;

   // The configuration byte is decoded straight from its two live bits.
   assign cfg.radio_excl = cfg_byte_i[CFG_RADIO_EXCL_BIT];
   assign cfg.pulse_mode = cfg_byte_i[CFG_PULSE_MODE_BIT];

   // Divider producing one enable pulse every tenth of a second.
   always_comb begin
      div_nxt = div_r + 1'b1;
      tenth_nxt = 1'b0;
      if (div_r == DIV_W'(TENTH_CYCLES - 1)) begin
         div_nxt = '0;
         tenth_nxt = 1'b1;
      end
   end

   // Divider registers; reset restarts the tenth phase from zero.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         div_r <= '0;
         tenth_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         tenth_r <= tenth_nxt;
      end
   end

   // -------------------------------------------------------------------
   // Common alarm
   // -------------------------------------------------------------------
   logic alarm_nxt, err_nxt, fault_any;

   // Radio sync only counts when the configuration does not exclude it.
   // The relay is energised only while nothing at all is wrong, so a dead
   // board or lost supply also reads as an alarm.
   always_comb begin
      fault_any = ~sys_ok_i | (|line_fault)
                | (~radio_sync_status_i & ~cfg.radio_excl);
      alarm_nxt = ~fault_any;
      err_nxt = |line_fault;
   end

   // Relay and host flag are registered outputs. Reset leaves the relay
   // dropped, so the host sees an alarm until the first healthy cycle.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         alarm_relay_o <= 1'b0;
         host_err_o <= 1'b0;
      end else begin
         alarm_relay_o <= alarm_nxt;
         host_err_o <= err_nxt;
      end
   end

   // -------------------------------------------------------------------
   // Per-line supervision
   // -------------------------------------------------------------------
   for (genvar li = 0; li < NUM_LINES; li++) begin : g_line
      // Each line keeps its own sequencer, filter, pending count and
      // time, so a fault on one line never stalls the other.
      slfm_pstate_t st_r, st_nxt;
      logic mon_ok_r, mon_ok_nxt;
      logic dip_fault_r, dip_fault_nxt;
      logic [TENTH_W-1:0] low_r, low_nxt;
      logic [TENTH_W-1:0] cnt_r, cnt_nxt;
      logic [PEND_W-1:0] pend_r, pend_nxt;
      logic [TIME_W-1:0] time_r, time_nxt;
      logic pol_r, pol_nxt;
      logic [TENTH_W-1:0] width;
      logic [TIME_W-1:0] wrap;
      logic tick, done_ok;
      slfm_line_out_t out_nxt;

      // Pulse clocks must stop at once; time-code clocks ride out dips.
      // Line fault: immediate in pulse mode, filtered in time-code mode so
      // a brief dip does not stop the telegram.
      assign line_fault[li] = cfg.pulse_mode ? ~mon_ok_r
                                              : dip_fault_r;

      // ----------------------------------------------------------------
      // Monitor filter, width select and pulse sequencer
      // ----------------------------------------------------------------
      // One process computes every next value of the line; the monitor
      // compare is registered once, which adds a cycle of fault latency.
      always_comb begin
         mon_ok_nxt = mon_level_i[li] >= mon_thresh_i;
         low_nxt = low_r;
         dip_fault_nxt = dip_fault_r;
         if (mon_ok_r) begin
            low_nxt = '0;
            dip_fault_nxt = 1'b0;
         end else if (tenth_r) begin
            if (low_r >= TENTH_W'(DIP_TENTHS - 1)) begin
               dip_fault_nxt = 1'b1;
            end else begin
               low_nxt = low_r + 1'b1;
            end
         end
         // Clamping keeps a bad setting from making a zero-length pulse.
         // Second lines use a fixed width; minute widths are clamped.
         if (line_is_sec_i[li]) begin
            width = TENTH_W'(PW_SEC_TENTHS);
         end else if (pw_tenths_i[li] < 5'(PW_MIN_TENTHS)) begin
            width = TENTH_W'(PW_MIN_TENTHS);
         end else if (pw_tenths_i[li] > 5'(PW_MAX_TENTHS)) begin
            width = TENTH_W'(PW_MAX_TENTHS);
         end else begin
            width = TENTH_W'(pw_tenths_i[li]);
         end
         wrap = line_is_sec_i[li] ? TIME_W'(SEC_PER_DAY - 1)
                                  : TIME_W'(MIN_PER_DAY - 1);
         // The host tick that matters depends on the kind of line.
         tick = line_is_sec_i[li] ? second_tick_i : minute_tick_i;
         st_nxt = st_r;
         cnt_nxt = cnt_r;
         pend_nxt = pend_r;
         time_nxt = time_r;
         pol_nxt = pol_r;
         done_ok = 1'b0;
         out_nxt = line_o[li];
         out_nxt.drive = 1'b0;
         // Missed pulses pile up here while the line is halted.
         if (cfg.pulse_mode && tick && pend_r != {PEND_W{1'b1}}) begin
            pend_nxt = pend_r + 1'b1;
         end
         // IDLE waits for a queued pulse, DRIVE holds the line for the
         // set width, and GAP spaces pulses apart or delays a retry.
         // A failed pulse keeps its polarity so the clockwork sees it again.
         case (st_r)
            SLFM_IDLE: begin
               if (cfg.pulse_mode && pend_r != '0) begin
                  st_nxt = SLFM_DRIVE;
                  cnt_nxt = width;
               end
            end
            SLFM_DRIVE: begin
               out_nxt.drive = 1'b1;
               if (~mon_ok_r || ~cfg.pulse_mode) begin
                  // Pulse lost: halt and retry later at the same polarity.
                  out_nxt.drive = 1'b0;
                  out_nxt.lamp = 1'b1;
                  st_nxt = SLFM_GAP;
                  cnt_nxt = TENTH_W'(RETRY_TENTHS);
               end else if (tenth_r) begin
                  if (cnt_r <= TENTH_W'(1)) begin
                     out_nxt.drive = 1'b0;
                     done_ok = 1'b1;
                     pol_nxt = ~pol_r;
                     pend_nxt = pend_nxt - 1'b1;
                     st_nxt = SLFM_GAP;
                     cnt_nxt = width;
                  end else begin
                     cnt_nxt = cnt_r - 1'b1;
                  end
               end
            end
            SLFM_GAP: begin
               if (tenth_r) begin
                  if (cnt_r <= TENTH_W'(1)) begin
                     st_nxt = SLFM_IDLE;
                  end else begin
                     cnt_nxt = cnt_r - 1'b1;
                  end
               end
            end
            default: begin
               st_nxt = SLFM_IDLE;
            end
         endcase
         // Polarity on the pin turns together with the falling edge of a
         // delivered pulse, so drive and polarity never disagree.
         out_nxt.pol = pol_nxt;
         // -------------------------------------------------------------
         // Time-code path and error lamp
         // -------------------------------------------------------------
         // Time-code mode forwards the telegram unless the line is faulty.
         out_nxt.tc = ~cfg.pulse_mode & ~line_fault[li]
                    & tc_bit_i[li];
         out_nxt.backup = BACKUP_FITTED & ~cfg.pulse_mode
                        & line_fault[li];
         // The lamp clears only on a completed minute with the line
         // healthy: a delivered minute pulse in pulse mode, the host minute
         // tick in time-code mode; a second line in pulse mode keeps its lamp lit.
         if (~cfg.pulse_mode && line_fault[li]) begin
            out_nxt.lamp = 1'b1;
         end else if (~line_fault[li] && ~out_nxt.lamp) begin
            out_nxt.lamp = 1'b0;
         end else if (~line_fault[li]
                      && (cfg.pulse_mode ? (done_ok & ~line_is_sec_i[li])
                                         : minute_tick_i)) begin
            out_nxt.lamp = 1'b0;
         end
         // -------------------------------------------------------------
         // Line time
         // -------------------------------------------------------------
         // Line time advances only on pulses actually delivered, or on host
         // ticks while healthy in time-code mode, so it holds the last output time across a fault.
         if (done_ok || (~cfg.pulse_mode && tick && ~line_fault[li])) begin
            time_nxt = (time_r == wrap) ? '0 : time_r + 1'b1;
         end
      end

      // ----------------------------------------------------------------
      // Line registers
      // ----------------------------------------------------------------
      // Reset drops pending pulses, and the line time restarts at zero.
      always_ff @(posedge clk_sys_i) begin
         if (rst_i) begin
            st_r <= SLFM_IDLE;
            mon_ok_r <= 1'b0;
            dip_fault_r <= 1'b0;
            low_r <= '0;
            cnt_r <= '0;
            pend_r <= '0;
            time_r <= '0;
            pol_r <= 1'b0;
            line_o[li] <= '0;
            line_time_o[li] <= '0;
         end else begin
            st_r <= st_nxt;
            mon_ok_r <= mon_ok_nxt;
            dip_fault_r <= dip_fault_nxt;
            low_r <= low_nxt;
            cnt_r <= cnt_nxt;
            pend_r <= pend_nxt;
            time_r <= time_nxt;
            pol_r <= pol_nxt;
            line_o[li] <= out_nxt;
            line_time_o[li] <= time_nxt;
         end
      end
   end
endmodule // slfm_top

/* File: inc/slfm_pkg.sv */
// Package of constants and carrier types for the slave line fault monitor.
package slfm_pkg;
   // -------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned TENTH_US = 100000;
   localparam int unsigned TENTH_CYC = TENTH_US * CLK_MHZ;
   localparam int unsigned PW_MIN_TENTHS = 2;
   localparam int unsigned PW_MAX_TENTHS = 30;
   localparam int unsigned PW_SEC_TENTHS = 2;
   localparam int unsigned RETRY_TENTHS = 10;
   localparam int unsigned DIP_TENTHS = 5;
   localparam int unsigned MIN_PER_DAY = 1440;
   localparam int unsigned SEC_PER_DAY = 86400;
   // -------------------------------------------------------------------
   // Widths and configuration bit positions
   // -------------------------------------------------------------------
   localparam int unsigned TENTH_W = 6;
   localparam int unsigned PEND_W = 8;
   localparam int unsigned TIME_W = 17;
   localparam int unsigned MON_W = 8;
   localparam int unsigned CFG_RADIO_EXCL_BIT = 7;
   localparam int unsigned CFG_PULSE_MODE_BIT = 6;
   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef struct packed {
      logic radio_excl;
      logic pulse_mode;
   } slfm_cfg_t;
   typedef struct packed {
      logic drive;
      logic pol;
      logic tc;
      logic backup;
      logic lamp;
   } slfm_line_out_t;
   typedef enum logic [1:0] {
      SLFM_IDLE,
      SLFM_DRIVE,
      SLFM_GAP
   } slfm_pstate_t;
endpackage

/* File: verif/slfm_chk.sv */
// Port checker for the slave line fault monitor.
`timescale 1ns/1ps
module slfm_chk #(
   parameter int unsigned NUM_LINES = 2
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [7:0] cfg_byte_i,
   input wire logic sys_ok_i,
   input wire logic radio_sync_status_i,
   input wire logic [NUM_LINES-1:0][slfm_pkg::MON_W-1:0] mon_level_i,
   input wire logic [slfm_pkg::MON_W-1:0] mon_thresh_i,
   input wire logic alarm_relay_o,
   input wire logic host_err_o,
   input wire slfm_pkg::slfm_line_out_t [NUM_LINES-1:0] line_o,
   input wire logic [NUM_LINES-1:0][slfm_pkg::TIME_W-1:0] line_time_o
);
   import slfm_pkg::*;
   // Qualified fault causes, kept as wires so each property stays short.
   wire rad_bad = !radio_sync_status_i && !cfg_byte_i[7];
   wire mon0_low = cfg_byte_i[6] && (mon_level_i[0] < mon_thresh_i);
   wire pm = cfg_byte_i[6];
   // All checks run on the system clock and pause during reset.
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   a_sys_alarm: assert property (!sys_ok_i |=> !alarm_relay_o)
      else $error("alarm up during system fault");
   a_radio_alarm: assert property (rad_bad |=> !alarm_relay_o)
      else $error("alarm up during radio fault");
   a_err_alarm: assert property (host_err_o |-> !alarm_relay_o)
      else $error("host error without alarm");
   a_backup_gate: assert property (line_o[1].backup |-> !line_o[1].tc)
      else $error("time code sent on backup supply");
   a_pol_hold: assert property (line_o[0].drive && $past(line_o[0].drive)
      |-> $stable(line_o[0].pol)) else $error("polarity moved in pulse");
   a_pol_flip: assert property ($fell(line_o[0].drive) && !line_o[0].lamp
      |-> $changed(line_o[0].pol)) else $error("polarity not toggled");
   a_time_step: assert property (pm && $changed(line_time_o[0])
      |-> $fell(line_o[0].drive)
      && (line_time_o[0] == $past(line_time_o[0]) + 17'h1
      || line_time_o[0] == 17'h0)) else $error("line time jumped");
   a_mon_halt: assert property (line_o[0].drive && mon0_low
      |-> ##[1:3] !line_o[0].drive) else $error("pulse kept on bad line");
   // Main scenarios that the bench is expected to reach.
   c_lamp: cover property ($rose(line_o[0].lamp));
   c_backup: cover property ($rose(line_o[1].backup));
   c_alarm: cover property ($fell(alarm_relay_o));
endmodule // slfm_chk
bind slfm_top slfm_chk #(.NUM_LINES(NUM_LINES)) u_slfm_chk (
   .clk_sys_i, .rst_i, .cfg_byte_i, .sys_ok_i, .radio_sync_status_i,
   .mon_level_i, .mon_thresh_i, .alarm_relay_o, .host_err_o, .line_o,
   .line_time_o
);

/* File: verif/slfm_line_model.sv */
// Behavioural model of two slave lines feeding the monitor inputs.
`timescale 1ns/1ps
module slfm_line_model (
   input wire logic clk_sys_i,
   input wire logic [1:0] fault_i,
   input wire logic [7:0] thresh_i,
   output logic [1:0][7:0] mon_level_o
);
   logic [7:0] noise_r = 8'h5a;
   // Healthy readings wander so a stuck compare cannot hide.
   always @(posedge clk_sys_i) begin
      noise_r <= {noise_r[6:0], noise_r[7] ^ noise_r[5]};
   end
   // A faulted line reads half the threshold, like a sagging supply.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         mon_level_o[i] = fault_i[i] ? (thresh_i >> 1)
            : thresh_i + {2'h0, noise_r[5:0]};
      end
   end
endmodule // slfm_line_model

/* File: verif/tb_top.sv */
// Self-checking bench for the slave line fault monitor.
`timescale 1ns/1ps
module tb_top;
   import slfm_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] cfg_byte_i = 8'h40;
   logic sys_ok_i = 1'b1;
   logic radio_sync_status_i = 1'b1;
   logic minute_tick_i = 1'b0;
   logic second_tick_i = 1'b0;
   logic [1:0] tc_bit_i = 2'h0;
   logic [1:0] line_is_sec_i = 2'h2;
   logic [1:0][4:0] pw_tenths_i = 10'h042;
   logic [1:0][7:0] mon_level_i;
   logic [7:0] mon_thresh_i = 8'h80;
   logic [1:0] fault = 2'h0;
   logic alarm_relay_o;
   logic host_err_o;
   slfm_line_out_t [1:0] line_o;
   logic [1:0][16:0] line_time_o;
   logic [31:0] seed = 32'ha1f6573a;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int exp_time[2] = '{0, 0};
   slfm_top #(.NUM_LINES(2), .TENTH_CYCLES(8)) u_slfm_top (.*);
   slfm_line_model u_slfm_line_model (.clk_sys_i(clk_sys_i),
      .fault_i(fault), .thresh_i(mon_thresh_i), .mon_level_o(mon_level_i));
   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   // Pulse mode queues every tick; a time-code line steps while healthy.
   task automatic tick(input int ln);
      @(negedge clk_sys_i);
      minute_tick_i = (ln == 0);
      second_tick_i = (ln == 1);
      exp_time[ln] += (cfg_byte_i[6] || !fault[ln]);
      @(negedge clk_sys_i);
      minute_tick_i = 1'b0;
      second_tick_i = 1'b0;
   endtask
   task automatic wait_done(input int ln);
      int n;
      n = 0;
      while (line_time_o[ln] !== exp_time[ln][16:0] && n < 3000) begin
         n++;
         cyc(1);
      end
      check(line_time_o[ln], exp_time[ln]);
      check(line_o[ln].pol, exp_time[ln] & 1);
   endtask
   // Width may lose up to one tenth to the phase of the tenth enable.
   task automatic meas(input int ln, input int pw);
      int w;
      int n;
      w = 0;
      n = 0;
      while (line_o[ln].drive !== 1'b1 && n < 2000) begin
         n++;
         cyc(1);
      end
      while (line_o[ln].drive === 1'b1 && w < 300) begin
         w++;
         cyc(1);
      end
      pw = pw < 2 ? 2 : (pw > 30 ? 30 : pw);
      check(w >= (pw - 1) * 8 && w < pw * 8, 1);
   endtask
   // -------------------------------------------------------------------
   // Clock, timeout and main sequence
   // -------------------------------------------------------------------
   initial begin
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         print_verdict();
      end
   end
   initial begin
      seed = xs(seed);
      pw_tenths_i = seed[9:0];
      cyc(6);
      check(alarm_relay_o, 0);
      rst_i = 1'b0;
      cyc(4);
      check(alarm_relay_o, 1);
      for (int k = 0; k < 3; k++) begin
         sys_ok_i = (k != 0);
         radio_sync_status_i = (k == 0);
         cfg_byte_i[7] = (k == 2);
         cyc(3);
         check(alarm_relay_o, k == 2);
         sys_ok_i = 1'b1;
         radio_sync_status_i = 1'b1;
         cyc(3);
         check(alarm_relay_o, 1);
      end
      tick(0);
      meas(0, pw_tenths_i[0]);
      tick(1);
      meas(1, 2);
      tick(0);
      tick(0);
      tick(1);
      wait_done(0);
      wait_done(1);
      tick(0);
      tick(0);
      while (line_o[0].drive !== 1'b1) begin
         cyc(1);
      end
      fault[0] = 1'b1;
      cyc(200);
      check(line_o[0].lamp, 1);
      check(alarm_relay_o, 0);
      check(host_err_o, 1);
      check(line_o[1].lamp, 0);
      check(line_time_o[0], exp_time[0] - 2);
      fault[0] = 1'b0;
      wait_done(0);
      check(alarm_relay_o, 1);
      tick(0);
      wait_done(0);
      check(line_o[0].lamp, 0);
      cfg_byte_i = 8'h00;
      repeat (20) begin
         seed = xs(seed);
         tc_bit_i = seed[1:0];
         cyc(1);
         check({line_o[1].tc, line_o[0].tc}, tc_bit_i);
      end
      tc_bit_i = 2'h3;
      fault[1] = 1'b1;
      cyc(14);
      check({line_o[1].tc, line_o[1].backup}, 2);
      fault[1] = 1'b0;
      cyc(4);
      fault[1] = 1'b1;
      tick(0);
      cyc(80);
      check(line_time_o[0], exp_time[0]);
      check({line_o[1].backup, line_o[1].lamp}, 3);
      check(alarm_relay_o, 0);
      fault[1] = 1'b0;
      cyc(16);
      check({line_o[1].tc, line_o[1].backup}, 2);
      check(line_o[1].lamp, 1);
      tick(0);
      cyc(4);
      check(line_o[1].lamp, 0);
      print_verdict();
   end
endmodule // tb_top
